// file: dv/scd_coarse_delay_checker.sv
`timescale 1ns/1ps
module scd_coarse_delay_checker (
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   input wire [15:0] rdata,
   input wire [11:0] delay_coarse_code,
   input wire [5:0] delay_fine_code,
   input wire duty_cycle_stabilizer_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence wr_c(bit s);
      wr_en && addr == 4'hC && wdata[3] == s ##1 !wr_en;
   endsequence
   chk_clamp_code: assert property (wr_c(1) |=> delay_coarse_code ==
      ($past(wdata[15:4], 2) > 12'h97F ? 12'h97F : $past(wdata[15:4], 2)))
      else $error("coarse code");
   chk_sel_gate: assert property (wr_c(0) |=> delay_coarse_code == 12'h0
      && delay_fine_code == 6'h0) else $error("select gate");
   chk_stab_bit: assert property (wr_c(1) |=>
      duty_cycle_stabilizer_enable == $past(wdata[2], 2)) else $error("dcs");
   chk_rsv_read: assert property (rd_en |=> rdata[1:0] == 2'h0)
      else $error("reserved bits");
   chk_bad_addr: assert property (rd_en && addr < 4'hC |=> rdata == 16'h0)
      else $error("unmapped read");
   chk_read_back: assert property (wr_c(1) ##1 rd_en && addr == 4'hC |=>
      rdata == ($past(wdata, 3) & 16'hFFFC)) else $error("read back");
endmodule // scd_coarse_delay_checker
bind scd_coarse_delay scd_coarse_delay_checker CHK (.*);

// file: dv/scd_host.sv
`timescale 1ns/1ps
module scd_host (
   input wire clk,
   output logic wr_en = 1'b0,
   output logic rd_en = 1'b0,
   output logic [3:0] addr = 4'h0,
   output logic [15:0] wdata = 16'h0
);
   task automatic acc(input bit w, input [3:0] a, input [15:0] d);
      @(negedge clk);
      {wr_en, rd_en, addr, wdata} = {w, !w, a, d};
      @(negedge clk);
      {wr_en, rd_en, wdata} = {2'h0, ~d};
   endtask
endmodule // scd_host

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, resetn = 1'b0, wr_en, rd_en, dcs, rv = 1'b0;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, v, lf = 16'h2492, q[$];
   logic [11:0] cc;
   logic [5:0] fc;
   int n_fail = 0, compares = 0;
   always #2.5 clk = ~clk;
   scd_coarse_delay DUT (.clk(clk), .resetn(resetn), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
      .delay_coarse_code(cc), .delay_fine_code(fc),
      .duty_cycle_stabilizer_enable(dcs));
   scd_host HOST (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wdata(wdata));
   function automatic [15:0] lfsr(input [15:0] x);
      lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task chk(input string n, input [15:0] s, input [15:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   always @(posedge clk) begin
      if (rv) chk("rdata", rdata, q.pop_front());
      rv <= rd_en;
   end
   task rd(input [3:0] a, input [15:0] e);
      q.push_back(e);
      HOST.acc(1'b0, a, 16'h0);
   endtask
   task finish_test;
      $display("n_fail %0d compares %0d", n_fail, compares);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #2000 n_fail++;
      finish_test;
   end
   initial begin
      repeat (12) @(negedge clk);
      resetn = 1'b1;
      chk("dcs", {15'h0, dcs}, 16'h0001);
      rd(4'hC, 16'h0004);
      rd(4'hD, 16'h0000);
      rd(4'h3, 16'h0000);
      HOST.acc(1'b1, 4'hC, 16'hFFFF);
      @(negedge clk);
      chk("cc", {4'h0, cc}, 16'h097F);
      rd(4'hC, 16'hFFFC);
      HOST.acc(1'b1, 4'hD, 16'hFC00);
      rd(4'hD, 16'hFC00);
      @(negedge clk);
      chk("fc", {10'h0, fc}, 16'h003F);
      repeat (20) begin
         lf = lfsr(lf);
         v = (lf & 16'hFFF0) | 16'h0008;
         HOST.acc(1'b1, 4'hC, v);
         rd(4'hC, v);
      end
      HOST.acc(1'b1, 4'hC, 16'h5550);
      @(negedge clk);
      chk("cc", {4'h0, cc}, 16'h0000);
      chk("fc", {10'h0, fc}, 16'h0000);
      chk("dcs", {15'h0, dcs}, 16'h0000);
      repeat (2) @(negedge clk);
      finish_test;
   end
endmodule // tb

// file: rtl/scd_coarse_delay.v
`timescale 1ns/1ps
// Functional notes
// - A 12-bit coarse delay code sits in bits 15..4 of register Ch.
// - Delay rises linearly from 0 at code 0 to 825 ps at code 2431.
// - Codes 2432 and above hold the delay at its maximum.
// - The coarse delay applies only while the select bit 3 is set.
// - While select bit 3 is set, a fine register at Dh adds finer steps on the same clock path.
`include "scd_defs.vh"

module scd_coarse_delay (
   input wire clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [3:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rdata,
   output reg [11:0] delay_coarse_code,
   output reg [5:0] delay_fine_code,
   output reg duty_cycle_stabilizer_enable
);

   // ==================================================================
   // Register storage
   reg [11:0] coarse_delay_magnitude_r;
   reg aperture_adjust_select_r;
   reg dcs_r;
   reg [5:0] fine_delay_magnitude_r;
   wire [11:0] coarse_applied;
   wire [5:0] fine_applied;
   wire [15:0] coarse_word;
   wire [15:0] fine_word;
   localparam [15:0] COARSE_RST = `SCD_COARSE_RESET;
   localparam [15:0] FINE_RST = `SCD_FINE_RESET;

   function [15:0] scd_rd_mux;
      input [3:0] a;
      input [15:0] cw;
      input [15:0] fw;
      begin
         case (a)
            `SCD_ADDR_COARSE: scd_rd_mux = cw;
            `SCD_ADDR_FINE: scd_rd_mux = fw;
            default: scd_rd_mux = 16'h0000;
         endcase
      end
   endfunction

   // Reserved bits 1:0 read as zero whatever was written
   assign coarse_word = {coarse_delay_magnitude_r, aperture_adjust_select_r,
      dcs_r, 2'b00};
   assign fine_word = {fine_delay_magnitude_r, 10'h000};

   always @(posedge clk) begin
      if (!resetn) begin
         coarse_delay_magnitude_r <=
            COARSE_RST[`SCD_COARSE_MSB:`SCD_COARSE_LSB];
         aperture_adjust_select_r <= COARSE_RST[`SCD_SEL_BIT];
         dcs_r <= COARSE_RST[`SCD_DCS_BIT];
         fine_delay_magnitude_r <= FINE_RST[`SCD_FINE_MSB:`SCD_FINE_LSB];
      end else if (wr_en) begin
         if (addr == `SCD_ADDR_COARSE) begin
            coarse_delay_magnitude_r <=
               wdata[`SCD_COARSE_MSB:`SCD_COARSE_LSB];
            aperture_adjust_select_r <= wdata[`SCD_SEL_BIT];
            dcs_r <= wdata[`SCD_DCS_BIT];
         end
         if (addr == `SCD_ADDR_FINE) begin
            fine_delay_magnitude_r <=
               wdata[`SCD_FINE_MSB:`SCD_FINE_LSB];
         end
      end
   end

   // ==================================================================
   // Applied delay codes
   scd_delay_calc u_calc (
      .coarse_code(coarse_delay_magnitude_r),
      .fine_code(fine_delay_magnitude_r),
      .select(aperture_adjust_select_r),
      .coarse_applied(coarse_applied),
      .fine_applied(fine_applied)
   );

   always @(posedge clk) begin
      if (!resetn) begin
         delay_coarse_code <= 12'h000;
         delay_fine_code <= 6'h00;
         duty_cycle_stabilizer_enable <= 1'b1;
         rdata <= 16'h0000;
      end else begin
         delay_coarse_code <= coarse_applied;
         delay_fine_code <= fine_applied;
         duty_cycle_stabilizer_enable <= dcs_r;
         if (rd_en) begin
            rdata <= scd_rd_mux(addr, coarse_word, fine_word);
         end
      end
   end

endmodule // scd_coarse_delay

// file: rtl/scd_defs.vh
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH
// Register addresses (4-bit serial port address)
`define SCD_ADDR_COARSE 4'hC
`define SCD_ADDR_FINE 4'hD
// Coarse register fields
`define SCD_COARSE_MSB 15
`define SCD_COARSE_LSB 4
`define SCD_SEL_BIT 3
`define SCD_DCS_BIT 2
`define SCD_COARSE_RESET 16'h0004
`define SCD_FINE_RESET 16'h0000
// Fine register field
`define SCD_FINE_MSB 15
`define SCD_FINE_LSB 10
// Coarse code range
`define SCD_COARSE_MAX 12'h97F
// Delay figures
`define SCD_MAX_DELAY_PS 825
`define SCD_STEP_FS 340
`endif

// file: rtl/scd_delay_calc.v
`timescale 1ns/1ps
// =====================================================================
// Delay code clamp and gating
module scd_delay_calc (
   input wire [11:0] coarse_code,
   input wire [5:0] fine_code,
   input wire select,
   output wire [11:0] coarse_applied,
   output wire [5:0] fine_applied
);

   function [11:0] scd_clamp;
      input [11:0] code;
      begin
         if (code > `SCD_COARSE_MAX) begin
            scd_clamp = `SCD_COARSE_MAX;
         end else begin
            scd_clamp = code;
         end
      end
   endfunction

   assign coarse_applied = select ? scd_clamp(coarse_code) : 12'h000;
   assign fine_applied = select ? fine_code : 6'h00;

endmodule // scd_delay_calc
